// ==== rtl/branch_pkg.sv ====
// Shared constants and types for the flag-clear branch unit
package branch_pkg;

   // -----------------------------------------------------------------
   // Widths and opcodes
   // -----------------------------------------------------------------
   localparam int unsigned PC_W = 21;
   localparam logic [7:0] OP_CARRY_CLEAR    = 8'he3;
   localparam logic [7:0] OP_NEGATIVE_CLEAR = 8'he7;
   localparam logic [7:0] OP_OVERFLOW_CLEAR = 8'he5;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [PC_W-1:0] WORD_STEP = 21'h000002;

   // -----------------------------------------------------------------
   // Quarter phase and flag positions
   // -----------------------------------------------------------------
   localparam logic [1:0] PHASE_Q1 = 2'h0;
   localparam logic [1:0] PHASE_Q2 = 2'h1;
   localparam logic [1:0] PHASE_Q3 = 2'h2;
   localparam logic [1:0] PHASE_Q4 = 2'h3;

   typedef struct packed {
      logic negative;
      logic overflow;
      logic zero;
      logic digit_carry;
      logic carry;
   } flags_t;

   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_CARRY,
      SEL_NEGATIVE,
      SEL_OVERFLOW
   } cond_sel_t;

endpackage

// ==== rtl/branch_target.sv ====
// Branch target adder: incremented pc plus doubled signed offset
`timescale 1ns/1ps
module branch_target (
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rstn,
   // Operands
   input  wire logic [branch_pkg::PC_W-1:0] pc_inc,
   input  wire logic [7:0]                offset,
   input  wire logic                      load,
   // Result
   output logic      [branch_pkg::PC_W-1:0] target
);
   import branch_pkg::*;

   logic [PC_W-1:0] target_reg;
   logic [PC_W-1:0] target_next;

   // Sign-extend n, double it, add to advanced pc
   always_comb begin
      target_next = target_reg;
      if (load) begin
         target_next = pc_inc +
            {{(PC_W-9){offset[7]}}, offset, 1'b0};
      end
   end

   // Hold the computed target
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         target_reg <= PC_RESET;
      end else begin
         target_reg <= target_next;
      end
   end

   assign target = target_reg;

endmodule // branch_target

// ==== rtl/cond_branch_not_flag.sv ====
// Decoder and executer of the three flag-clear relative branches
// How it works
// - Opcode e3 branches only while carry is clear, else falls through.
// - Opcode e7 branches only while negative is clear, else falls through.
// - Opcode e5 branches only while overflow is clear, else falls through.
// - Low byte is a signed offset from -128 to 127.
// - Taken target is incremented pc plus twice the offset.
// - Pc already advanced past the branch word when offset is applied.
// - One word; one cycle untaken, two taken with a no-op cycle.
`timescale 1ns/1ps
module cond_branch_not_flag (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        rstn,
   // Fetch side
   input  wire logic [15:0]                 instr_word,
   input  wire logic                        instr_valid,
   // Status flags
   input  wire branch_pkg::flags_t          flags_in,
   // Program counter side
   output logic      [branch_pkg::PC_W-1:0] pc,
   output logic      [1:0]                  phase,
   output logic                             fetch_stall,
   output logic                             branch_taken,
   output branch_pkg::flags_t               flags_out
);
   import branch_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic {ST_EXEC, ST_FLUSH} state_t;

   state_t          state_reg,  state_next;
   logic [1:0]      phase_reg,  phase_next;
   logic [PC_W-1:0] pc_reg,     pc_next;
   logic [7:0]      offset_reg, offset_next;
   logic            go_reg,     go_next;
   logic            stall_reg,  stall_next;
   logic            taken_reg,  taken_next;
   flags_t          flags_reg,  flags_next;
   logic [PC_W-1:0] target;
   cond_sel_t       sel_reg,    sel_next;

   // Opcode decode into a condition selector
   function automatic cond_sel_t decode(input logic [7:0] op);
      unique case (op)
         OP_CARRY_CLEAR:    decode = SEL_CARRY;
         OP_NEGATIVE_CLEAR: decode = SEL_NEGATIVE;
         OP_OVERFLOW_CLEAR: decode = SEL_OVERFLOW;
         default:           decode = SEL_NONE;
      endcase
   endfunction

   // Branch condition: selected flag must be zero
   function automatic logic cond_met(input cond_sel_t s,
                                     input flags_t f);
      unique case (s)
         SEL_CARRY:    cond_met = !f.carry;
         SEL_NEGATIVE: cond_met = !f.negative;
         SEL_OVERFLOW: cond_met = !f.overflow;
         SEL_NONE:     cond_met = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Target adder
   // ----------------------------------------------------------------
   branch_target u_target (
      .clock  (clock),
      .rstn   (rstn),
      .pc_inc (pc_reg),
      .offset (offset_reg),
      .load   (phase_reg == PHASE_Q3),
      .target (target)
   );

   // ----------------------------------------------------------------
   // Branch control
   // ----------------------------------------------------------------
   // Quarter phase sequencing and branch control
   always_comb begin
      phase_next  = phase_reg + 2'h1;
      state_next  = state_reg;
      pc_next     = pc_reg;
      offset_next = offset_reg;
      sel_next    = sel_reg;
      go_next     = go_reg;
      stall_next  = stall_reg;
      taken_next  = 1'b0;
      flags_next  = flags_reg;
      unique case (phase_reg)
         PHASE_Q1: begin
            if (state_reg == ST_EXEC) begin
               sel_next = instr_valid ? decode(instr_word[15:8])
                                      : SEL_NONE;
               // Pc moves past the word during fetch
               if (instr_valid) begin
                  pc_next = pc_reg + WORD_STEP;
               end
            end
            flags_next = flags_in;
         end
         PHASE_Q2: begin
            offset_next = instr_word[7:0];
         end
         PHASE_Q3: begin
            go_next = (state_reg == ST_EXEC) &&
                      cond_met(sel_reg, flags_in);
         end
         PHASE_Q4: begin
            if (state_reg == ST_FLUSH) begin
               state_next = ST_EXEC;
               stall_next = 1'b0;
            end else if (go_reg) begin
               pc_next    = target;
               state_next = ST_FLUSH;
               stall_next = 1'b1;
               taken_next = 1'b1;
            end
            sel_next = SEL_NONE;
            go_next  = 1'b0;
         end
      endcase
   end

   // Register all control state
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= ST_EXEC;
         phase_reg  <= PHASE_Q1;
         pc_reg     <= PC_RESET;
         offset_reg <= 8'h00;
         sel_reg    <= SEL_NONE;
         go_reg     <= 1'b0;
         stall_reg  <= 1'b0;
         taken_reg  <= 1'b0;
         flags_reg  <= '0;
      end else begin
         state_reg  <= state_next;
         phase_reg  <= phase_next;
         pc_reg     <= pc_next;
         offset_reg <= offset_next;
         sel_reg    <= sel_next;
         go_reg     <= go_next;
         stall_reg  <= stall_next;
         taken_reg  <= taken_next;
         flags_reg  <= flags_next;
      end
   end

   // Outputs straight from flip-flops
   assign pc           = pc_reg;
   assign phase        = phase_reg;
   assign fetch_stall  = stall_reg;
   assign branch_taken = taken_reg;
   assign flags_out    = flags_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   chk_pc_write_q4: assert property (
      (phase_reg != PHASE_Q4 && phase_reg != PHASE_Q1 &&
       state_reg == ST_EXEC) |=> $stable(pc_reg))
      else $error("pc changed outside its write quarters");
   chk_carry_taken: assert property (
      (phase_reg == PHASE_Q3 && state_reg == ST_EXEC &&
       sel_reg == SEL_CARRY) |=> (go_reg == !$past(flags_in.carry)))
      else $error("carry clear branch decision wrong");
   chk_neg_taken: assert property (
      (phase_reg == PHASE_Q3 && state_reg == ST_EXEC &&
       sel_reg == SEL_NEGATIVE) |=> (go_reg == !$past(flags_in.negative)))
      else $error("negative clear branch decision wrong");
   chk_ovf_taken: assert property (
      (phase_reg == PHASE_Q3 && state_reg == ST_EXEC &&
       sel_reg == SEL_OVERFLOW) |=> (go_reg == !$past(flags_in.overflow)))
      else $error("overflow clear branch decision wrong");
   chk_target_math: assert property (
      (phase_reg == PHASE_Q4 && go_reg && state_reg == ST_EXEC) |=>
      (pc_reg == $past(pc_reg) +
       {{(PC_W-9){$past(offset_reg[7])}}, $past(offset_reg), 1'b0}))
      else $error("branch target not pc plus twice offset");
   chk_flush_cycle: assert property (
      branch_taken |-> fetch_stall ##4 !fetch_stall)
      else $error("taken branch flush not one cycle");
   chk_untaken_fall: assert property (
      (phase_reg == PHASE_Q4 && !go_reg && state_reg == ST_EXEC) |=>
      (!branch_taken && $stable(pc_reg)))
      else $error("untaken branch disturbed pc");
   chk_flags_kept: assert property (
      (phase_reg != PHASE_Q1) |=> $stable(flags_reg))
      else $error("flags changed by branch");
   chk_phase_step: assert property (
      1'b1 |=> (phase_reg == $past(phase_reg) + 2'h1))
      else $error("quarter phase did not advance by one");
   chk_flush_refuse: assert property (
      (phase_reg == PHASE_Q1 && state_reg == ST_FLUSH) |=>
      $stable(pc_reg))
      else $error("pc advanced during the no-op cycle");
   chk_fetch_advance: assert property (
      (phase_reg == PHASE_Q1 && state_reg == ST_EXEC && instr_valid) |=>
      (pc_reg == $past(pc_reg) + WORD_STEP))
      else $error("pc not advanced past the fetched word");
   chk_taken_pulse: assert property (
      branch_taken |=> !branch_taken)
      else $error("branch taken pulse longer than one clock");
   chk_offset_read: assert property (
      (phase_reg == PHASE_Q2) |=> (offset_reg == $past(instr_word[7:0])))
      else $error("offset not read in the second quarter");

   cov_taken:   cover property (branch_taken);
   cov_carry:   cover property (phase_reg == PHASE_Q4 &&
                                sel_reg == SEL_CARRY && !go_reg);
   cov_back:    cover property (branch_taken && offset_reg[7]);
   cov_overflow: cover property (go_reg && sel_reg == SEL_OVERFLOW);
   cov_refused: cover property (phase_reg == PHASE_Q1 &&
                                state_reg == ST_FLUSH && instr_valid);

endmodule // cond_branch_not_flag

// ==== verification/fetch_model.sv ====
// Partner model of the fetch unit and status flags
`timescale 1ns/1ps
module fetch_model (
   // Clock
   input  wire logic          clock,
   // Fetch and flag outputs
   output logic [15:0]        instr_word,
   output logic               instr_valid,
   output branch_pkg::flags_t flags_in
);
   import branch_pkg::*;

   // Idle state at time zero
   initial begin
      instr_word = 16'h0000;
      instr_valid = 1'b0;
      flags_in = flags_t'(5'h00);
   end

   // Offer a word in Q1, hold it through Q2, then let it go
   task automatic issue(input logic [15:0] w, input flags_t f);
      instr_word = w;
      instr_valid = 1'b1;
      flags_in = f;
      @(negedge clock);
      instr_valid = 1'b0;
      @(negedge clock);
      instr_word = ~w; // Released lines stop showing the word
   endtask
endmodule // fetch_model

// ==== verification/testbench.sv ====
// Self-checking bench for the flag-clear branch unit
`timescale 1ns/1ps
module testbench;
   import branch_pkg::*;
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic            taken;
      flags_t          flags;
   } note_t;
   logic            clock;
   logic            rstn;
   logic [15:0]     instr_word;
   logic            instr_valid;
   flags_t          flags_in;
   logic [PC_W-1:0] pc;
   logic [1:0]      phase;
   logic            fetch_stall;
   logic            branch_taken;
   flags_t          flags_out;
   note_t           notes[$];
   note_t           cur;
   logic [PC_W-1:0] exp_pc;
   logic            stall_due;
   logic [1:0]      prev_phase;
   logic            prev_stall;
   logic            prev_rstn;
   logic [7:0]      ops [5];
   flags_t          masks [3];
   int              mismatches;
   int              checks;
   int              cycles;

   fetch_model u_fetch_model (.clock(clock), .instr_word(instr_word),
      .instr_valid(instr_valid), .flags_in(flags_in));
   cond_branch_not_flag u_cond_branch_not_flag (.clock(clock), .rstn(rstn),
      .instr_word(instr_word), .instr_valid(instr_valid),
      .flags_in(flags_in), .pc(pc), .phase(phase),
      .fetch_stall(fetch_stall), .branch_taken(branch_taken),
      .flags_out(flags_out));

   // Clock and hang limit
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         end_sim();
      end
   end

   task automatic end_sim();
      if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Compare tasks, one per kind of result
   task automatic check_pc(string s, logic [PC_W-1:0] e, logic [PC_W-1:0] g);
      checks = checks + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic check_bit(string s, logic e, logic g);
      checks = checks + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic check_phase(string s, logic [1:0] e, logic [1:0] g);
      checks = checks + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic check_flags(string s, flags_t e, flags_t g);
      checks = checks + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask

   // Oldest note against each finished non-stall instruction cycle
   always @(negedge clock) begin
      // Quarter phase steps by one every clock once out of reset
      if (rstn === 1'b1 && prev_rstn === 1'b1) begin
         check_phase("phase", prev_phase + 2'h1, phase);
      end
      if (phase === PHASE_Q1 && prev_phase === PHASE_Q4
          && prev_stall === 1'b0 && notes.size() > 0) begin
         cur = notes.pop_front();
         check_pc("pc", cur.pc, pc);
         check_bit("taken", cur.taken, branch_taken);
         check_bit("fetch_stall", cur.taken, fetch_stall);
         check_flags("flags_out", cur.flags, flags_out);
      end
      prev_phase = phase;
      prev_stall = fetch_stall;
      prev_rstn = rstn;
   end

   task automatic wait_q1();
      @(negedge clock);
      while (phase !== PHASE_Q1) @(negedge clock);
   endtask

   // Run one word; a word offered in the stall cycle must be ignored
   task automatic run_instr(input logic [15:0] w, input flags_t f);
      logic tk;
      if (stall_due) begin
         wait_q1();
         u_fetch_model.issue(~w, f);
      end
      wait_q1();
      case (w[15:8])
         OP_CARRY_CLEAR:    tk = ~f.carry;
         OP_NEGATIVE_CLEAR: tk = ~f.negative;
         OP_OVERFLOW_CLEAR: tk = ~f.overflow;
         default:           tk = 1'b0;
      endcase
      exp_pc = exp_pc + WORD_STEP;
      if (tk) exp_pc = exp_pc + {{12{w[7]}}, w[7:0], 1'b0};
      stall_due = tk;
      u_fetch_model.issue(w, f);
      // Noted only now, so the end of an earlier cycle cannot take it
      notes.push_back('{exp_pc, tk, f});
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      exp_pc = PC_RESET;
      stall_due = 1'b0;
      prev_phase = PHASE_Q1;
      prev_stall = 1'b0;
      prev_rstn = 1'b0;
      mismatches = 0;
      checks = 0;
      cycles = 0;
      ops = '{OP_CARRY_CLEAR, OP_NEGATIVE_CLEAR, OP_OVERFLOW_CLEAR,
              8'he2, 8'h0f};
      masks = '{flags_t'(5'h01), flags_t'(5'h10), flags_t'(5'h08)};
      void'($urandom(32'hf794435f));
      repeat (2) @(negedge clock);
      check_pc("pc reset", PC_RESET, pc);
      check_bit("stall reset", 1'b0, fetch_stall);
      check_flags("flags reset", flags_t'(5'h00), flags_out);
      rstn = 1'b1;
      // Each opcode with its flag clear and set, at both offset limits
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 4; k++) begin
            run_instr({ops[i], k[1] ? 8'h7f : 8'h80},
                      k[0] ? masks[i] : flags_t'(~masks[i]));
         end
      end
      // Random mix, other opcodes included, back to back
      repeat (40) begin
         run_instr({ops[$urandom_range(4)], 8'($urandom)},
                   flags_t'(5'($urandom)));
      end
      repeat (16) @(negedge clock);
      check_bit("notes_drained", 1'b1, notes.size() == 0);
      end_sim();
   end
endmodule // testbench
